// ### sdwpc_core.sv
// Synchronous DRAM write burst, precharge, power-down and clock suspend logic
`timescale 1ns/1ps
`default_nettype none
`include "sdwpc_params.svh"
module sdwpc_core (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Command pins
   input wire logic clk_gate,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [1:0] bank_addr,
   input wire logic [11:0] addr,
   input wire logic byte_mask,
   input wire logic [`SDWPC_DQ_W-1:0] dq_in,
   // Configuration
   input wire logic [2:0] burst_len_code,
   input wire logic write_burst_mode_bit,
   input wire logic read_active,
   // Array write port
   output logic mem_we,
   output logic [1:0] mem_bank,
   output logic [`SDWPC_COL_W-1:0] mem_col,
   output logic [`SDWPC_DQ_W-1:0] mem_data,
   // Data pin drive and status
   output logic dq_oe,
   output logic in_buf_en,
   output logic power_down,
   output logic active_power_down,
   output logic suspended,
   output logic [`SDWPC_BANKS-1:0] bank_open,
   output logic [`SDWPC_BANKS-1:0] bank_busy
);
   // ========================================================================
   // Command decode
   sdwpc_pkg::sdwpc_cmd_t cmd;
   always_comb begin
      cmd = sdwpc_pkg::SDWPC_CMD_NOP;
      if (!cs_n) begin
         case ({ras_n, cas_n, we_n})
            3'h4: cmd = sdwpc_pkg::SDWPC_CMD_WRITE;
            3'h2: cmd = sdwpc_pkg::SDWPC_CMD_PRE;
            3'h6: cmd = sdwpc_pkg::SDWPC_CMD_STOP;
            default: cmd = sdwpc_pkg::SDWPC_CMD_NOP;
         endcase
      end
   end
   logic is_nop;
   assign is_nop = cs_n | ({ras_n, cas_n, we_n} == 3'h7);
   logic is_read;
   assign is_read = !cs_n && ({ras_n, cas_n, we_n} == 3'h5);
   logic is_act;
   assign is_act = !cs_n && ({ras_n, cas_n, we_n} == 3'h3);
   // ========================================================================
   // State and burst counters
   sdwpc_pkg::sdwpc_state_t st_q, st_d;
   logic [`SDWPC_COL_W-1:0] col_q, col_d;
   logic [8:0] left_q, left_d;
   logic [1:0] bank_q, bank_d;
   logic ap_q, ap_d, full_q, full_d;
   logic we_d, pd_act_d;
   logic [`SDWPC_COL_W-1:0] wcol_d;
   logic [1:0] wbank_d;
   logic [`SDWPC_BANKS-1:0] open_req, pre_req, ap_req, ap_cancel;
   logic [8:0] blen;
   logic tick;
   logic [`SDWPC_BANKS-1:0] busy_w, open_w;
   always_comb begin
      case (burst_len_code)
         3'h0: blen = 9'h001;
         3'h1: blen = 9'h002;
         3'h2: blen = 9'h004;
         3'h3: blen = 9'h008;
         default: blen = 9'h100;
      endcase
      if (write_burst_mode_bit) begin
         blen = 9'h001;
      end
   end
   always_comb begin
      st_d = st_q;
      col_d = col_q;
      left_d = left_q;
      bank_d = bank_q;
      ap_d = ap_q;
      full_d = full_q;
      we_d = 1'b0;
      wcol_d = col_q;
      wbank_d = bank_q;
      pd_act_d = active_power_down;
      tick = 1'b1;
      open_req = '0;
      pre_req = '0;
      ap_req = '0;
      ap_cancel = '0;
      case (st_q)
         sdwpc_pkg::SDWPC_ST_PDOWN: begin
            tick = 1'b0;
            if (clk_gate) begin
               st_d = sdwpc_pkg::SDWPC_ST_IDLE;
            end
         end
         sdwpc_pkg::SDWPC_ST_SUSP: begin
            tick = 1'b0;
            if (clk_gate) begin
               st_d = sdwpc_pkg::SDWPC_ST_WRITE;
            end
         end
         default: begin
            if (cmd == sdwpc_pkg::SDWPC_CMD_WRITE) begin
               if (st_q == sdwpc_pkg::SDWPC_ST_WRITE && ap_q && bank_q != bank_addr) begin
                  ap_req[bank_q] = 1'b1;
               end
               bank_d = bank_addr;
               ap_d = addr[`SDWPC_AP_BIT];
               full_d = (blen == 9'h100);
               we_d = !byte_mask;
               wcol_d = addr[`SDWPC_COL_W-1:0];
               wbank_d = bank_addr;
               col_d = addr[`SDWPC_COL_W-1:0] + `SDWPC_COL_W'(1);
               ap_cancel[bank_addr] = 1'b1;
               if (blen == 9'h001) begin
                  st_d = sdwpc_pkg::SDWPC_ST_IDLE;
                  if (addr[`SDWPC_AP_BIT]) begin
                     ap_req[bank_addr] = 1'b1;
                  end
               end else begin
                  st_d = sdwpc_pkg::SDWPC_ST_WRITE;
                  left_d = blen - 9'h001;
               end
            end else if (st_q == sdwpc_pkg::SDWPC_ST_WRITE
                         && (is_read || cmd == sdwpc_pkg::SDWPC_CMD_STOP)) begin
               st_d = sdwpc_pkg::SDWPC_ST_IDLE;
               if (ap_q) begin
                  ap_req[bank_q] = 1'b1;
               end
            end else if (cmd == sdwpc_pkg::SDWPC_CMD_PRE) begin
               if (addr[`SDWPC_AP_BIT]) begin
                  pre_req = '1;
               end else begin
                  pre_req[bank_addr] = 1'b1;
               end
               if (st_q == sdwpc_pkg::SDWPC_ST_WRITE
                   && (addr[`SDWPC_AP_BIT] || bank_addr == bank_q)) begin
                  st_d = sdwpc_pkg::SDWPC_ST_IDLE;
               end else if (st_q == sdwpc_pkg::SDWPC_ST_WRITE) begin
                  we_d = !byte_mask;
                  col_d = col_q + `SDWPC_COL_W'(1);
               end
            end else if (st_q == sdwpc_pkg::SDWPC_ST_WRITE) begin
               we_d = !byte_mask;
               col_d = col_q + `SDWPC_COL_W'(1);
               if (!full_q) begin
                  left_d = left_q - 9'h001;
                  if (left_q == 9'h001) begin
                     st_d = sdwpc_pkg::SDWPC_ST_IDLE;
                     if (ap_q) begin
                        ap_req[bank_q] = 1'b1;
                     end
                  end
               end
            end else if (!clk_gate && is_nop && !read_active) begin
               st_d = sdwpc_pkg::SDWPC_ST_PDOWN;
               pd_act_d = |open_w;
            end else if (is_act) begin
               open_req[bank_addr] = 1'b1;
            end
            if (!clk_gate && st_d == sdwpc_pkg::SDWPC_ST_WRITE) begin
               st_d = sdwpc_pkg::SDWPC_ST_SUSP;
            end
         end
      endcase
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= sdwpc_pkg::SDWPC_ST_IDLE;
         col_q <= '0;
         left_q <= '0;
         bank_q <= '0;
         ap_q <= 1'b0;
         full_q <= 1'b0;
         mem_we <= 1'b0;
         mem_col <= '0;
         mem_bank <= '0;
         mem_data <= '0;
         active_power_down <= 1'b0;
      end else begin
         st_q <= st_d;
         col_q <= col_d;
         left_q <= left_d;
         bank_q <= bank_d;
         ap_q <= ap_d;
         full_q <= full_d;
         mem_we <= we_d;
         mem_col <= wcol_d;
         mem_bank <= wbank_d;
         mem_data <= dq_in;
         active_power_down <= pd_act_d;
      end
   end
   // ========================================================================
   // Bank timers
   genvar gi;
   generate
      for (gi = 0; gi < `SDWPC_BANKS; gi = gi + 1) begin : g_bank
         sdwpc_bank_timer u_tmr (
            .core_clk(core_clk),
            .resetn(resetn),
            .open_req(open_req[gi]),
            .pre_req(pre_req[gi]),
            .ap_req(ap_req[gi]),
            .ap_cancel(ap_cancel[gi]),
            .clk_en(tick),
            .row_open(open_w[gi]),
            .busy(busy_w[gi])
         );
      end
   endgenerate
   // ========================================================================
   // Registered status outputs
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         dq_oe <= 1'b0;
         in_buf_en <= 1'b1;
         power_down <= 1'b0;
         suspended <= 1'b0;
         bank_open <= '0;
         bank_busy <= '0;
      end else begin
         dq_oe <= 1'b0;
         in_buf_en <= (st_d != sdwpc_pkg::SDWPC_ST_PDOWN);
         power_down <= (st_d == sdwpc_pkg::SDWPC_ST_PDOWN);
         suspended <= (st_d == sdwpc_pkg::SDWPC_ST_SUSP);
         bank_open <= open_w;
         bank_busy <= busy_w;
      end
   end
endmodule
`default_nettype wire

// ### sdwpc_params.svh
// Constants for the synchronous DRAM write, precharge and power control block
// ==========================================================================
`ifndef SDWPC_PARAMS_SVH
`define SDWPC_PARAMS_SVH
`define SDWPC_CLK_PERIOD_NS 100
`define SDWPC_WR_EXTRA_NS 8
`define SDWPC_WR_CYCLES (1 + ((`SDWPC_WR_EXTRA_NS + `SDWPC_CLK_PERIOD_NS - 1) / `SDWPC_CLK_PERIOD_NS))
`define SDWPC_RP_NS 20
`define SDWPC_RP_CYCLES ((`SDWPC_RP_NS + `SDWPC_CLK_PERIOD_NS - 1) / `SDWPC_CLK_PERIOD_NS)
`define SDWPC_COL_W 8
`define SDWPC_DQ_W 16
`define SDWPC_BANKS 4
`define SDWPC_AP_BIT 10
`define SDWPC_TMR_W 4
`endif

// ### sdwpc_pkg.sv
// Types for the synchronous DRAM write, precharge and power control block
package sdwpc_pkg;
   typedef enum logic [3:0] {
      SDWPC_CMD_NOP = 4'h1,
      SDWPC_CMD_WRITE = 4'h2,
      SDWPC_CMD_PRE = 4'h4,
      SDWPC_CMD_STOP = 4'h8
   } sdwpc_cmd_t;
   typedef enum logic [4:0] {
      SDWPC_ST_IDLE = 5'h01,
      SDWPC_ST_WRITE = 5'h02,
      SDWPC_ST_SUSP = 5'h04,
      SDWPC_ST_PDOWN = 5'h08,
      SDWPC_ST_READ = 5'h10
   } sdwpc_state_t;
endpackage

// ### sdwpc_bank_timer.sv
// Per-bank recovery and precharge timer
`timescale 1ns/1ps
`default_nettype none
`include "sdwpc_params.svh"
module sdwpc_bank_timer (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Control
   input wire logic open_req,
   input wire logic pre_req,
   input wire logic ap_req,
   input wire logic ap_cancel,
   input wire logic clk_en,
   // Status
   output logic row_open,
   output logic busy
);
   logic [`SDWPC_TMR_W-1:0] wr_q, wr_d, rp_q, rp_d;
   logic open_q, open_d, ap_q, ap_d;
   always_comb begin
      wr_d = wr_q;
      rp_d = rp_q;
      open_d = open_q;
      ap_d = ap_q;
      if (clk_en) begin
         if (rp_q != '0) begin
            rp_d = rp_q - `SDWPC_TMR_W'(1);
         end
         if (ap_q) begin
            if (wr_q > `SDWPC_TMR_W'(1)) begin
               wr_d = wr_q - `SDWPC_TMR_W'(1);
            end else begin
               ap_d = 1'b0;
               open_d = 1'b0;
               rp_d = `SDWPC_TMR_W'(`SDWPC_RP_CYCLES);
            end
         end
         if (ap_cancel) begin
            ap_d = 1'b0;
         end
         if (ap_req) begin
            ap_d = 1'b1;
            wr_d = `SDWPC_TMR_W'(`SDWPC_WR_CYCLES);
         end
         if (pre_req) begin
            open_d = 1'b0;
            ap_d = 1'b0;
            rp_d = `SDWPC_TMR_W'(`SDWPC_RP_CYCLES);
         end
         if (open_req) begin
            open_d = 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rp_q <= '0;
         open_q <= 1'b0;
         ap_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rp_q <= rp_d;
         open_q <= open_d;
         ap_q <= ap_d;
      end
   end
   assign row_open = open_q;
   assign busy = ap_q | (rp_q != '0);
endmodule
`default_nettype wire

// ### sdwpc_properties.sv
// Port checker for the write, precharge and power control block
`timescale 1ns/1ps
`default_nettype none
`include "sdwpc_params.svh"
module sdwpc_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Command pins
   input wire logic clk_gate,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [11:0] addr,
   input wire logic byte_mask,
   input wire logic [`SDWPC_DQ_W-1:0] dq_in,
   input wire logic write_burst_mode_bit,
   input wire logic read_active,
   // Watched outputs
   input wire logic mem_we,
   input wire logic [`SDWPC_COL_W-1:0] mem_col,
   input wire logic [`SDWPC_DQ_W-1:0] mem_data,
   input wire logic dq_oe,
   input wire logic in_buf_en,
   input wire logic power_down,
   input wire logic suspended
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic live = clk_gate & !suspended & !power_down;
   wire logic wr = live & !cs_n & ras_n & !cas_n & !we_n;
   wire logic stp = live & !cs_n & ras_n & cas_n & !we_n;
   wire logic rd = live & !cs_n & ras_n & !cas_n & we_n;
   wire logic no_operation_cmd = cs_n | (ras_n & cas_n & we_n);
   wire logic pd_go = !clk_gate & no_operation_cmd & !read_active;
   sequence s_wr;
      wr && !byte_mask;
   endsequence
   sequence s_single;
      wr && write_burst_mode_bit ##1 !wr;
   endsequence
   dq_release_a: assert property (!dq_oe)
      else $error("data pins driven");
   first_elem_a: assert property (s_wr |=> mem_we && mem_col == $past(addr[7:0])
      && mem_data == $past(dq_in)) else $error("first element lost");
   mask_zero_a: assert property (byte_mask |=> !mem_we)
      else $error("masked element written");
   stop_drop_a: assert property (stp |=> !mem_we)
      else $error("stop data written");
   read_block_a: assert property (rd |=> !mem_we)
      else $error("write after read");
   single_col_a: assert property (s_single |=> !mem_we)
      else $error("second column written");
   pd_entry_a: assert property ($rose(power_down) |-> $past(pd_go))
      else $error("power-down without cause");
   pd_quiet_a: assert property (power_down |-> !in_buf_en && !mem_we)
      else $error("buffers live in power-down");
   pd_exit_a: assert property (power_down && clk_gate && no_operation_cmd |=> !power_down)
      else $error("power-down not left");
   susp_freeze_a: assert property (suspended |=> !mem_we)
      else $error("write on suspended edge");
   susp_exit_a: assert property (suspended && clk_gate |=> !suspended)
      else $error("suspend not left");
endmodule
bind sdwpc_core sdwpc_properties chk_i (.core_clk(core_clk), .resetn(resetn),
   .clk_gate(clk_gate), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
   .addr(addr), .byte_mask(byte_mask), .dq_in(dq_in), .read_active(read_active),
   .write_burst_mode_bit(write_burst_mode_bit), .mem_we(mem_we), .mem_col(mem_col),
   .mem_data(mem_data), .dq_oe(dq_oe), .in_buf_en(in_buf_en),
   .power_down(power_down), .suspended(suspended));
`default_nettype wire

// ### sdwpc_ctrl_model.sv
// Memory controller model driving commands, mask and write data
`timescale 1ns/1ps
`default_nettype none
`include "sdwpc_params.svh"
module sdwpc_ctrl_model (
   // Clock
   input wire logic core_clk,
   // Command, mask and data pins
   output logic clk_gate,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [1:0] bank_addr,
   output logic [11:0] addr,
   output logic byte_mask,
   output logic [`SDWPC_DQ_W-1:0] dq_in
);
   // One command per clock, launched just after the edge
   task op(input logic [3:0] s, input logic [1:0] b, input logic [11:0] a,
      input logic m, input logic [15:0] d, input logic g);
      @(posedge core_clk);
      {cs_n, ras_n, cas_n, we_n} <= s;
      clk_gate <= g;
      bank_addr <= b;
      addr <= a;
      byte_mask <= m;
      dq_in <= d;
   endtask
   // Masked idle gap, released data inverted
   task idle(input int n);
      repeat (n) op(4'h7, 2'h0, 12'h000, 1'b1, ~dq_in, 1'b1);
   endtask
endmodule
`default_nettype wire

// ### sdwpc_tb.sv
// Self-checking bench for the write, precharge and power control block
`timescale 1ns/1ps
`default_nettype none
`include "sdwpc_params.svh"
module tb;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [2:0] burst_len_code = 3'h1;
   logic write_burst_mode_bit = 1'b0;
   logic read_active = 1'b0;
   wire logic clk_gate, cs_n, ras_n, cas_n, we_n, byte_mask;
   wire logic [1:0] bank_addr;
   wire logic [11:0] addr;
   wire logic [`SDWPC_DQ_W-1:0] dq_in;
   logic mem_we, dq_oe, in_buf_en, power_down, active_power_down, suspended;
   logic [1:0] mem_bank;
   logic [`SDWPC_COL_W-1:0] mem_col;
   logic [`SDWPC_DQ_W-1:0] mem_data;
   logic [`SDWPC_BANKS-1:0] bank_open, bank_busy;
   int fail_count = 0;
   int cmp_count = 0;
   logic [25:0] seen[$];
   sdwpc_ctrl_model ctl (.core_clk(core_clk), .clk_gate(clk_gate), .cs_n(cs_n),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr),
      .byte_mask(byte_mask), .dq_in(dq_in));
   sdwpc_core uut (.core_clk(core_clk), .resetn(resetn), .clk_gate(clk_gate),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr),
      .addr(addr), .byte_mask(byte_mask), .dq_in(dq_in), .burst_len_code(burst_len_code),
      .write_burst_mode_bit(write_burst_mode_bit), .read_active(read_active),
      .mem_we(mem_we), .mem_bank(mem_bank), .mem_col(mem_col), .mem_data(mem_data),
      .dq_oe(dq_oe), .in_buf_en(in_buf_en), .power_down(power_down),
      .active_power_down(active_power_down), .suspended(suspended),
      .bank_open(bank_open), .bank_busy(bank_busy));
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (mem_we === 1'b1) begin
         seen.push_back({mem_bank, mem_col, mem_data});
      end
   end
   task complete_run;
      $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [25:0] e, input logic [25:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task ex(input logic [1:0] b, input logic [7:0] c, input logic [15:0] d, input int n);
      logic [25:0] got;
      for (int k = 0; k < n; k++) begin
         got = (seen.size() > 0) ? seen.pop_front() : 26'h3FFFFFF;
         chk("element", {b, c + 8'(k), d + 16'(k)}, got);
      end
   endtask
   task fin(input string nm);
      chk("count", 26'h0, 26'(seen.size()));
      $display("%s done", nm);
   endtask
   task wr(input logic [1:0] b, input logic [7:0] c, input logic ap, input logic [15:0] d,
      input int n);
      ctl.op(4'h4, b, {1'b0, ap, 2'h0, c}, 1'b0, d, 1'b1);
      for (int k = 1; k < n; k++) ctl.op(4'h7, 2'h0, 12'h000, 1'b0, d + 16'(k), 1'b1);
   endtask
   task run(input logic [2:0] bl, input logic [1:0] b, input logic [7:0] c,
      input logic [15:0] d, input int n, input int m);
      burst_len_code <= bl;
      ctl.idle(1);
      wr(b, c, 1'b0, d, n);
      ctl.idle(3);
      ex(b, c, d, m);
   endtask
   task t_burst;
      run(3'h1, 2'h0, 8'h05, 16'hA000, 4, 2);
      fin("burst");
   endtask
   task t_full;
      burst_len_code <= 3'h7;
      ctl.idle(1);
      wr(2'h1, 8'hFE, 1'b0, 16'hB000, 4);
      ctl.op(4'h6, 2'h1, 12'h000, 1'b0, 16'hB004, 1'b1);
      ctl.idle(3);
      ex(2'h1, 8'hFE, 16'hB000, 4);
      fin("full page");
   endtask
   task t_wrwr;
      burst_len_code <= 3'h2;
      ctl.idle(1);
      wr(2'h0, 8'h10, 1'b0, 16'hC000, 2);
      wr(2'h2, 8'h20, 1'b0, 16'hC100, 4);
      ctl.idle(3);
      ex(2'h0, 8'h10, 16'hC000, 2);
      ex(2'h2, 8'h20, 16'hC100, 4);
      fin("write after write");
   endtask
   task t_read;
      burst_len_code <= 3'h2;
      ctl.idle(1);
      wr(2'h3, 8'h30, 1'b0, 16'hD000, 2);
      read_active <= 1'b1;
      ctl.op(4'h5, 2'h0, 12'h000, 1'b0, 16'hD002, 1'b1);
      ctl.op(4'h7, 2'h0, 12'h000, 1'b0, 16'hD003, 1'b1);
      read_active <= 1'b0;
      ctl.idle(3);
      ex(2'h3, 8'h30, 16'hD000, 2);
      fin("read stop");
   endtask
   task t_susp;
      burst_len_code <= 3'h2;
      ctl.idle(1);
      ctl.op(4'h4, 2'h0, 12'h040, 1'b0, 16'hE000, 1'b1);
      ctl.op(4'h7, 2'h0, 12'h000, 1'b0, 16'hE001, 1'b0);
      ctl.op(4'h4, 2'h1, 12'h0AA, 1'b0, 16'h5555, 1'b1);
      ctl.op(4'h7, 2'h0, 12'h000, 1'b0, 16'hE002, 1'b1);
      ctl.op(4'h7, 2'h0, 12'h000, 1'b0, 16'hE003, 1'b1);
      ctl.idle(3);
      ex(2'h0, 8'h40, 16'hE000, 4);
      fin("suspend");
   endtask
   task t_single;
      write_burst_mode_bit <= 1'b1;
      run(3'h3, 2'h1, 8'h50, 16'hF000, 4, 1);
      write_burst_mode_bit <= 1'b0;
      fin("single write");
   endtask
   task t_ap;
      int n;
      int t;
      burst_len_code <= 3'h0;
      ctl.idle(1);
      wr(2'h1, 8'h60, 1'b1, 16'h1234, 1);
      n = 0;
      for (t = 0; t < 40 && !(n > 0 && bank_busy[1] === 1'b0); t++) begin
         ctl.idle(1);
         #1;
         if (bank_busy[1] === 1'b1) n++;
      end
      if (t == 40) begin
         fail_count++;
         complete_run();
      end
      chk("recovery", 26'h1, 26'(n >= `SDWPC_WR_CYCLES));
      ex(2'h1, 8'h60, 16'h1234, 1);
      fin("auto precharge");
   endtask
   task t_pre;
      ctl.op(4'h3, 2'h2, 12'h000, 1'b1, 16'h0000, 1'b1);
      wr(2'h2, 8'h70, 1'b0, 16'h2000, 1);
      ctl.idle(`SDWPC_WR_CYCLES);
      #1;
      chk("bank_open", 26'h4, 26'(bank_open));
      ctl.op(4'h2, 2'h0, 12'h400, 1'b1, 16'h0000, 1'b1);
      ctl.idle(3);
      #1;
      chk("bank_open", 26'h0, 26'(bank_open));
      ex(2'h2, 8'h70, 16'h2000, 1);
      fin("precharge all");
   endtask
   task t_pd;
      ctl.op(4'h3, 2'h0, 12'h000, 1'b1, 16'h0000, 1'b1);
      ctl.op(4'h7, 2'h0, 12'h000, 1'b1, 16'h0000, 1'b0);
      ctl.op(4'h4, 2'h0, 12'h080, 1'b0, 16'h3333, 1'b0);
      #1;
      chk("pd_state", 26'h5, 26'({power_down, in_buf_en, active_power_down}));
      ctl.op(4'h7, 2'h0, 12'h000, 1'b1, 16'hCCCC, 1'b1);
      ctl.idle(2);
      #1;
      chk("pd_exit", 26'h1, 26'({power_down, in_buf_en}));
      fin("power-down");
   endtask
   initial begin
      ctl.op(4'h7, 2'h0, 12'h000, 1'b1, 16'h0000, 1'b1);
      repeat (9) @(posedge core_clk);
      resetn <= 1'b1;
      t_burst();
      t_full();
      t_wrwr();
      t_read();
      t_susp();
      t_single();
      t_ap();
      t_pre();
      t_pd();
      complete_run();
   end
endmodule
`default_nettype wire
